// ### hw/spsl_pkg.sv
`default_nettype none
package spsl_pkg;
    localparam int unsigned STAGES       = 8;
    localparam int unsigned SYNC_DEPTH   = 3;
    localparam logic [7:0]  SHIFT_RST    = 8'h00;
    localparam logic [7:0]  STORE_RST    = 8'h00;
    localparam logic [7:0]  OE_RST       = 8'h00;
    localparam int unsigned CLK_PERIOD_NS = 8;

    typedef struct packed {
        logic serial_in;
        logic shift_clock;
        logic storage_clock;
        logic shift_clear_n;
        logic output_enable_n;
    } spsl_pins_s;

    // Idle pin levels: clocks low, clear released, outputs switched off.
    localparam spsl_pins_s  PIN_RST      = 5'h03;

    typedef logic [STAGES-1:0] spsl_byte_t;
endpackage
`default_nettype wire

// ### hw/spsl_top.sv
`default_nettype none
// Notes on behaviour
// - Eight-stage shift register, one bit per shift.
// - Storage register copies all eight stages.
// - Eight parallel outputs, level or high impedance.
// - Outputs driven only while enable input low.
// - Separate shift and storage clock inputs.
// - Both clocks act on rising edges.
// - Low clear zeroes shift stages, overrides shifting.
// - Last stage drives serial output for cascading.
// - Tied clocks: storage takes pre-edge shift contents.
module spsl_top
    import spsl_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       CE,
    input  wire spsl_pins_s PINS,
    output logic [7:0]      PARALLEL_OUT,
    output logic [7:0]      PARALLEL_OE,
    output logic            SERIAL_OUT
);
    // ==========================================================
    // Pin synchronisers
    // All pins are asynchronous; a change counts once the second
    // and third flops agree, which filters single-cycle glitches.
    localparam int unsigned NPIN = $bits(spsl_pins_s);
    logic [NPIN-1:0] s1_q, s2_q, s3_q, flt_q;
    logic [NPIN-1:0] s1_d, s2_d, s3_d, flt_d;
    spsl_pins_s      pin;
    logic            shclk_prev_q, stclk_prev_q;
    logic            shclk_prev_d, stclk_prev_d;
    logic            shift_rise, store_rise;
    spsl_byte_t      shift_q, shift_d, store_q, store_d;
    logic [7:0]      oe_q, oe_d;

    always_comb begin
        s1_d = PINS;
        s2_d = s1_q;
        s3_d = s2_q;
        flt_d = flt_q;
        for (int i = 0; i < NPIN; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                flt_d[i] = s3_q[i];
            end
        end
    end

    // The chain resets to the idle pin levels, so that no clock edge, clear
    // or enable is acted on before the real pins have been sampled.
    always_ff @(posedge CLK) begin
        if (RST) begin
            s1_q  <= PIN_RST;
            s2_q  <= PIN_RST;
            s3_q  <= PIN_RST;
            flt_q <= PIN_RST;
        end else if (CE) begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            flt_q <= flt_d;
        end
    end

    assign pin = spsl_pins_s'(flt_q);

    // ==========================================================
    // Edge detection
    always_comb begin
        shclk_prev_d = pin.shift_clock;
        stclk_prev_d = pin.storage_clock;
    end

    // The previous levels reset to the idle clock levels, so that leaving
    // reset never looks like a rising clock.
    always_ff @(posedge CLK) begin
        if (RST) begin
            shclk_prev_q <= PIN_RST.shift_clock;
            stclk_prev_q <= PIN_RST.storage_clock;
        end else if (CE) begin
            shclk_prev_q <= shclk_prev_d;
            stclk_prev_q <= stclk_prev_d;
        end
    end
    assign shift_rise = pin.shift_clock & ~shclk_prev_q;
    assign store_rise = pin.storage_clock & ~stclk_prev_q;

    // ==========================================================
    // Storage register
    // The copy is taken from the registered shift value, so when both
    // clocks rise together the storage gets the stages as they were.
    always_comb begin
        store_d = store_q;
        if (store_rise) begin
            store_d = shift_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            store_q <= STORE_RST;
        end else if (CE) begin
            store_q <= store_d;
        end
    end

    // ==========================================================
    // Shift register
    // Clear is a level seen through the synchroniser, so it acts a few
    // cycles after the pin falls rather than at once.
    always_comb begin
        shift_d = shift_q;
        if (!pin.shift_clear_n) begin
            shift_d = SHIFT_RST;
        end else if (shift_rise) begin
            shift_d = {shift_q[STAGES-2:0], pin.serial_in};
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            shift_q <= SHIFT_RST;
        end else if (CE) begin
            shift_q <= shift_d;
        end
    end

    // ==========================================================
    // Output enable
    always_comb begin
        oe_d = {STAGES{~pin.output_enable_n}};
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            oe_q <= OE_RST;
        end else if (CE) begin
            oe_q <= oe_d;
        end
    end

    assign PARALLEL_OUT = store_q;
    assign PARALLEL_OE  = oe_q;
    assign SERIAL_OUT   = shift_q[STAGES-1];

    // ==========================================================
    // Checks
    // Every result is registered, so each check looks one cycle after its cause.
    property p_shift;
        @(posedge CLK) disable iff (RST)
        (CE && shift_rise && pin.shift_clear_n) |=>
            shift_q == {$past(shift_q[6:0]), $past(pin.serial_in)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift step wrong");

    property p_store;
        @(posedge CLK) disable iff (RST)
        (CE && store_rise) |=> store_q == $past(shift_q);
    endproperty
    a_store: assert property (p_store) else $error("store copy wrong");

    property p_clear;
        @(posedge CLK) disable iff (RST)
        (CE && !pin.shift_clear_n) |=> shift_q == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_hold;
        @(posedge CLK) disable iff (RST)
        (CE && !store_rise) |=> $stable(store_q);
    endproperty
    a_hold: assert property (p_hold) else $error("storage changed");

    property p_oe;
        @(posedge CLK) disable iff (RST)
        CE |=> PARALLEL_OE == {8{~$past(pin.output_enable_n)}};
    endproperty
    a_oe: assert property (p_oe) else $error("enable wrong");

    property p_serial;
        @(posedge CLK) disable iff (RST)
        (CE && shift_rise && pin.shift_clear_n) |=> SERIAL_OUT == $past(shift_q[6]);
    endproperty
    a_serial: assert property (p_serial) else $error("serial out wrong");

    property p_noshift;
        @(posedge CLK) disable iff (RST)
        (CE && !shift_rise && pin.shift_clear_n) |=> $stable(shift_q);
    endproperty
    a_noshift: assert property (p_noshift) else $error("spurious shift");

    property p_out;
        @(posedge CLK) disable iff (RST)
        (CE && store_rise) |=> PARALLEL_OUT == $past(shift_q);
    endproperty
    a_out: assert property (p_out) else $error("output mismatch");

    property p_keep;
        @(posedge CLK) disable iff (RST)
        (CE && shift_rise && !store_rise) |=> $stable(PARALLEL_OUT);
    endproperty
    a_keep: assert property (p_keep) else $error("storage followed shift");

    property p_clear_keep;
        @(posedge CLK) disable iff (RST)
        (CE && !pin.shift_clear_n && !store_rise) |=> $stable(PARALLEL_OUT);
    endproperty
    a_clear_keep: assert property (p_clear_keep) else $error("clear hit outputs");

    property p_tied;
        @(posedge CLK) disable iff (RST)
        (CE && shift_rise && store_rise && pin.shift_clear_n) |=>
            PARALLEL_OUT == $past(shift_q) && SERIAL_OUT == $past(shift_q[6]);
    endproperty
    a_tied: assert property (p_tied) else $error("tied clocks out of step");

    c_tied: cover property (@(posedge CLK) disable iff (RST) shift_rise && store_rise);
    c_clear: cover property (@(posedge CLK) disable iff (RST) !pin.shift_clear_n && shift_rise);
    c_float: cover property (@(posedge CLK) disable iff (RST) PARALLEL_OE == 8'h00);
    c_store_only: cover property (@(posedge CLK) disable iff (RST) store_rise && !shift_rise);
    c_frozen: cover property (@(posedge CLK) disable iff (RST) !CE && shift_q != SHIFT_RST);
endmodule
`default_nettype wire

// ### tb/spsl_host_model.sv
`default_nettype none
module spsl_host_model
    import spsl_pkg::*;
(
    input  wire logic       CLK,
    output var  spsl_pins_s PINS
);
    timeunit 1ns;
    timeprecision 1ps;
    logic oe_n = 1'b0;
    initial PINS = 5'h02;
    // Each level stands 8 cycles, since the sampler loses anything under 2.
    task automatic hold(input spsl_pins_s p);
        PINS <= p;
        repeat (8) @(posedge CLK);
    endtask
    // With both clocks raised together the edges stay aligned.
    task automatic edge_on(input logic d, input logic sh, input logic st);
        hold({d, 1'b0, 1'b0, 1'b1, oe_n});
        hold({d, sh, st, 1'b1, oe_n});
        hold({d, 1'b0, 1'b0, 1'b1, oe_n});
    endtask
    task automatic send(input spsl_byte_t b);
        for (int i = 7; i >= 0; i--) begin
            edge_on(b[i], 1'b1, 1'b0);
        end
    endtask
    task automatic clear();
        hold({1'b0, 1'b0, 1'b0, 1'b0, oe_n});
        hold({1'b1, 1'b1, 1'b0, 1'b0, oe_n});
        hold({1'b0, 1'b0, 1'b0, 1'b1, oe_n});
    endtask
endmodule
`default_nettype wire

// ### tb/spsl_top_tb_top.sv
`default_nettype none
module spsl_top_tb_top
    import spsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       ce = 1'b1;
    spsl_pins_s pins;
    logic [7:0] pout;
    logic [7:0] poe;
    logic       sout;
    int         bad_count = 0;
    int         samples_checked = 0;
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    spsl_host_model host_u (.CLK(clk), .PINS(pins));
    spsl_top dut_u (.CLK(clk), .RST(rst), .CE(ce), .PINS(pins),
        .PARALLEL_OUT(pout), .PARALLEL_OE(poe), .SERIAL_OUT(sout));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic t_load();
        host_u.send(8'hb5);
        host_u.edge_on(1'b0, 1'b0, 1'b1);
        check(pout, 8'hb5);
        check(poe, 8'hff);
        check({7'h0, sout}, 8'h01);
        $display("load done");
    endtask
    task automatic t_clear();
        host_u.clear();
        check(pout, 8'hb5);
        check({7'h0, sout}, 8'h00);
        host_u.edge_on(1'b0, 1'b0, 1'b1);
        check(pout, 8'h00);
        $display("clear done");
    endtask
    task automatic t_tied();
        host_u.send(8'h3c);
        host_u.edge_on(1'b1, 1'b1, 1'b1);
        check(pout, 8'h3c);
        host_u.edge_on(1'b0, 1'b0, 1'b1);
        check(pout, 8'h79);
        $display("tied done");
    endtask
    task automatic t_float();
        host_u.oe_n = 1'b1;
        host_u.edge_on(1'b0, 1'b0, 1'b0);
        check(poe, 8'h00);
        check(pout, 8'h79);
        host_u.oe_n = 1'b0;
        $display("float done");
    endtask
    task automatic t_freeze();
        ce <= 1'b0;
        host_u.edge_on(1'b0, 1'b1, 1'b1);
        check({7'h0, sout}, 8'h00);
        check(pout, 8'h79);
        ce <= 1'b1;
        host_u.edge_on(1'b0, 1'b0, 1'b1);
        check(pout, 8'h79);
        $display("freeze done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_load();
        t_clear();
        t_tied();
        t_freeze();
        t_float();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end
endmodule
`default_nettype wire
